// ### rtl/upfh_port.sv
// upfh_port: device side of the byte-wide parallel fifo port
// assumes strobes and data pins are asynchronous to i_clk_sys;
// the usb engine sits on the stream ports and runs on i_clk_sys.
module upfh_port
   import upfh_pkg::*;
#(
   parameter int DEPTH = UPFH_FIFO_DEPTH,
   parameter int RESUME_CYC = UPFH_RESUME_CYC
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // data bus pins
   input wire logic [UPFH_DATA_W-1:0] i_fifo_data,
   output logic [UPFH_DATA_W-1:0] o_fifo_data,
   output logic o_fifo_data_oe,
   // strobes
   input wire logic i_rd_strobe_n,
   input wire logic i_wr_strobe,
   // flags
   output logic o_tx_space_flag_n,
   output logic o_tx_space_flag_n_oe,
   input wire logic i_rx_data_flag_n,
   output logic o_rx_data_flag_n,
   output logic o_rx_data_flag_n_oe,
   // power and suspend
   output logic o_power_enable_n,
   output logic o_pull_down_en,
   // oscillator cell
   input wire logic i_osc_in,
   output logic o_osc_out,
   // options and usb state
   input wire logic i_remote_wake_en,
   input wire logic i_suspend_pull_en,
   input wire logic i_usb_configured,
   input wire logic i_usb_suspended,
   output logic o_resume_req,
   // receive stream from usb engine
   input wire logic i_rx_valid,
   input wire logic [UPFH_DATA_W-1:0] i_rx_data,
   output logic o_rx_ready,
   // transmit stream to usb engine
   output logic o_tx_valid,
   output logic [UPFH_DATA_W-1:0] o_tx_data,
   input wire logic i_tx_ready
);
   localparam int RW = $clog2(RESUME_CYC + 1);
   localparam int FW = $clog2(UPFH_WAKE_FILT_CYC + 1);
   localparam int LW = $clog2(DEPTH + 1);

   logic [2:0] strb_sync;
   logic rd_n_s;
   logic wr_s;
   logic wake_n_s;
   logic [UPFH_DATA_W-1:0] data_s;
   logic rd_n_d_reg;
   logic wr_d_reg;
   logic rd_fall;
   logic wr_fall;
   logic rx_out_valid;
   logic [UPFH_DATA_W-1:0] rx_out_data;
   logic tx_in_ready;
   logic [UPFH_DATA_W-1:0] rd_byte_reg;
   logic byte_held_reg;
   logic rd_pop;
   logic [UPFH_DATA_W-1:0] wr_byte;
   logic in_reset_reg;
   logic suspend_reg;
   logic wake_mode;
   logic [FW-1:0] wake_cnt_reg;
   logic wake_armed_reg;
   logic [RW-1:0] resume_cnt_reg;
   logic data_oe_reg;
   logic [UPFH_DATA_W-1:0] data_out_reg;
   logic txf_reg;
   logic rxf_reg;
   logic rxf_oe_reg;
   logic txf_oe_reg;
   logic power_enable_n_reg;
   logic pull_dn_reg;
   logic resume_reg;
   logic osc_reg;
   logic osc_s;
   logic [LW-1:0] rx_level_reg;
   logic [LW-1:0] rx_level_next;
   logic rx_ready_reg;
   logic rx_push;
   logic [LW-1:0] tx_level_reg;
   logic [LW-1:0] tx_level_next;
   logic tx_valid_reg;
   logic tx_pop;

   typedef enum logic [1:0] {
      UPFH_RD_IDLE,
      UPFH_RD_LOW
   } upfh_rd_state_type;
   upfh_rd_state_type rd_state_reg;

   // strobes and wake pin, idle high except write strobe
   upfh_sync #(
      .WIDTH(3),
      .RST_VAL({UPFH_STROBE_IDLE, 1'b0, UPFH_STROBE_IDLE})
   ) u_strb_sync (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_async({i_rd_strobe_n, i_wr_strobe, i_rx_data_flag_n}),
      .o_sync(strb_sync)
   );
   assign rd_n_s = strb_sync[2];
   assign wr_s = strb_sync[1];
   assign wake_n_s = strb_sync[0];

   // data bus, synchronised so it is settled at the write edge
   upfh_sync #(
      .WIDTH(UPFH_DATA_W),
      .RST_VAL(UPFH_DATA_RST)
   ) u_data_sync (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_async(i_fifo_data),
      .o_sync(data_s)
   );

   // oscillator pin, synchronised like every other pin
   upfh_sync #(
      .WIDTH(1),
      .RST_VAL(1'b0)
   ) u_osc_sync (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_async(i_osc_in),
      .o_sync(osc_s)
   );

   // receive fifo: usb engine fills, host drains
   upfh_fifo #(
      .WIDTH(UPFH_DATA_W),
      .DEPTH(DEPTH)
   ) u_rx_fifo (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_in_valid(rx_push),
      .i_in_data(i_rx_data),
      .o_in_ready(),
      .o_out_valid(rx_out_valid),
      .o_out_data(rx_out_data),
      .i_out_ready(rd_pop)
   );

   // transmit fifo: host fills, usb engine drains and may stall
   upfh_fifo #(
      .WIDTH(UPFH_DATA_W),
      .DEPTH(DEPTH)
   ) u_tx_fifo (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_in_valid(wr_fall),
      .i_in_data(wr_byte),
      .o_in_ready(tx_in_ready),
      .o_out_valid(),
      .o_out_data(o_tx_data),
      .i_out_ready(tx_pop)
   );

   // edge detection on synchronised strobes
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         rd_n_d_reg <= UPFH_STROBE_IDLE;
         wr_d_reg <= 1'b0;
      end else begin
         rd_n_d_reg <= rd_n_s;
         wr_d_reg <= wr_s;
      end
   end
   assign rd_fall = rd_n_d_reg && !rd_n_s;
   assign wr_fall = wr_d_reg && !wr_s;
   assign wr_byte = data_s;
   // pop only when a byte is there
   assign rd_pop = rd_fall && rx_out_valid && !suspend_reg;

   // fill level after one push and one pop
   function automatic logic [LW-1:0] upfh_level_step(input logic [LW-1:0] lvl,
      input logic inc, input logic dec);
      return lvl + LW'(inc) - LW'(dec);
   endfunction : upfh_level_step

   // fill levels mirrored so stream handshakes leave from flops
   assign rx_push = i_rx_valid && rx_ready_reg;
   assign tx_pop = tx_valid_reg && i_tx_ready;
   assign rx_level_next = upfh_level_step(rx_level_reg, rx_push, rd_pop);
   assign tx_level_next = upfh_level_step(tx_level_reg, wr_fall && tx_in_ready, tx_pop);
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         rx_level_reg <= '0;
         tx_level_reg <= '0;
         rx_ready_reg <= 1'b1;
         tx_valid_reg <= 1'b0;
      end else begin
         rx_level_reg <= rx_level_next;
         tx_level_reg <= tx_level_next;
         rx_ready_reg <= (rx_level_next != LW'(DEPTH));
         tx_valid_reg <= (tx_level_next != '0);
      end
   end

   // read sequence: latch byte at fall, hold it while low
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         rd_state_reg <= UPFH_RD_IDLE;
         rd_byte_reg <= UPFH_DATA_RST;
         byte_held_reg <= 1'b0;
      end else begin
         case (rd_state_reg)
            UPFH_RD_IDLE: begin
               if (rd_fall) begin
                  rd_state_reg <= UPFH_RD_LOW;
                  byte_held_reg <= rd_pop;
                  if (rd_pop) begin
                     rd_byte_reg <= rx_out_data;
                  end
               end
            end
            UPFH_RD_LOW: begin
               if (rd_n_s) begin
                  rd_state_reg <= UPFH_RD_IDLE;
               end
            end
            default: begin
               rd_state_reg <= UPFH_RD_IDLE;
            end
         endcase
      end
   end

   // bus drive while read strobe low outside suspend, released otherwise
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         data_oe_reg <= 1'b0;
         data_out_reg <= UPFH_DATA_RST;
      end else begin
         data_oe_reg <= !rd_n_s && !suspend_reg;
         data_out_reg <= rd_fall && rd_pop ? rx_out_data : rd_byte_reg;
      end
   end

   // reset tracking for flag tri-state
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         in_reset_reg <= 1'b1;
      end else begin
         in_reset_reg <= 1'b0;
      end
   end

   // flags: drop rx flag during a read so host sees next state fresh
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         txf_reg <= UPFH_FLAG_RST;
         rxf_reg <= UPFH_FLAG_RST;
         txf_oe_reg <= 1'b0;
         rxf_oe_reg <= 1'b0;
      end else begin
         txf_reg <= !tx_in_ready || wr_s;
         rxf_reg <= !rx_out_valid || !rd_n_s || suspend_reg;
         txf_oe_reg <= !in_reset_reg;
         rxf_oe_reg <= !in_reset_reg && !wake_mode;
      end
   end

   // power enable and suspend pull-down
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         power_enable_n_reg <= UPFH_POWER_ENABLE_N_RST;
         suspend_reg <= 1'b0;
         pull_dn_reg <= 1'b0;
      end else begin
         power_enable_n_reg <= !(i_usb_configured && !i_usb_suspended);
         suspend_reg <= i_usb_suspended;
         pull_dn_reg <= i_suspend_pull_en && i_usb_suspended;
      end
   end
   assign wake_mode = i_remote_wake_en && power_enable_n_reg && suspend_reg;

   // remote wakeup: filtered low pulse on rx flag pin
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         wake_cnt_reg <= '0;
         wake_armed_reg <= 1'b0;
         resume_cnt_reg <= '0;
         resume_reg <= 1'b0;
      end else begin
         if (!wake_mode || wake_n_s) begin
            wake_cnt_reg <= '0;
            wake_armed_reg <= wake_mode;
         end else if (wake_cnt_reg != FW'(UPFH_WAKE_FILT_CYC)) begin
            wake_cnt_reg <= wake_cnt_reg + FW'(1);
         end
         if (wake_armed_reg && wake_cnt_reg == FW'(UPFH_WAKE_FILT_CYC - 1)) begin
            resume_cnt_reg <= RW'(RESUME_CYC);
            wake_armed_reg <= 1'b0;
         end else if (resume_cnt_reg != '0) begin
            resume_cnt_reg <= resume_cnt_reg - RW'(1);
         end
         resume_reg <= (resume_cnt_reg != '0);
      end
   end

   // oscillator cell feedback, internal clock in use
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         osc_reg <= 1'b0;
      end else begin
         osc_reg <= !osc_s;
      end
   end

   assign o_fifo_data = data_out_reg;
   assign o_fifo_data_oe = data_oe_reg;
   assign o_tx_space_flag_n = txf_reg;
   assign o_tx_space_flag_n_oe = txf_oe_reg;
   assign o_rx_data_flag_n = rxf_reg;
   assign o_rx_data_flag_n_oe = rxf_oe_reg;
   assign o_power_enable_n = power_enable_n_reg;
   assign o_pull_down_en = pull_dn_reg;
   assign o_resume_req = resume_reg;
   assign o_osc_out = osc_reg;
   assign o_rx_ready = rx_ready_reg;
   assign o_tx_valid = tx_valid_reg;
endmodule : upfh_port

// ### rtl/upfh_pkg.sv
// upfh_pkg: shared constants for the parallel byte fifo port
// assumes a single 25 MHz system clock domain
package upfh_pkg;
   localparam int UPFH_DATA_W = 8;
   localparam int UPFH_FIFO_DEPTH = 8;
   localparam int UPFH_CLK_MHZ = 25;
   localparam int UPFH_OSC_MHZ = 12;
   // resume request pulse length, in microseconds and in cycles
   localparam int UPFH_RESUME_US = 1;
   localparam int UPFH_RESUME_CYC = UPFH_RESUME_US * UPFH_CLK_MHZ;
   // wake strobe must stay low one cycle fewer than this to count
   localparam int UPFH_WAKE_FILT_CYC = 3;
   // flag and data values seen after reset
   localparam logic UPFH_FLAG_RST = 1'b1;
   localparam logic UPFH_POWER_ENABLE_N_RST = 1'b1;
   localparam logic [7:0] UPFH_DATA_RST = 8'h00;
   // synchroniser reset level for strobes idle high
   localparam logic UPFH_STROBE_IDLE = 1'b1;
endpackage : upfh_pkg

// ### rtl/upfh_fifo.sv
// upfh_fifo: flip-flop fifo with valid/ready on both sides
// assumes one clock, synchronous active-high reset
module upfh_fifo
   import upfh_pkg::*;
#(
   parameter int WIDTH = UPFH_DATA_W,
   parameter int DEPTH = UPFH_FIFO_DEPTH
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // fill side
   input wire logic i_in_valid,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_in_ready,
   // drain side
   output logic o_out_valid,
   output logic [WIDTH-1:0] o_out_data,
   input wire logic i_out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   logic do_wr;
   logic do_rd;

   function automatic logic [AW-1:0] upfh_inc(input logic [AW-1:0] p);
      if (p == AW'(DEPTH - 1)) begin
         return '0;
      end
      return p + AW'(1);
   endfunction : upfh_inc

   assign o_in_ready = (count_reg != (AW+1)'(DEPTH));
   assign o_out_valid = (count_reg != '0);
   assign o_out_data = mem_reg[rd_ptr_reg];
   assign do_wr = i_in_valid && o_in_ready;
   assign do_rd = o_out_valid && i_out_ready;

   always_ff @(posedge i_clk_sys) begin
      if (do_wr) begin
         mem_reg[wr_ptr_reg] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (do_wr) begin
            wr_ptr_reg <= upfh_inc(wr_ptr_reg);
         end
         if (do_rd) begin
            rd_ptr_reg <= upfh_inc(rd_ptr_reg);
         end
         if (do_wr && !do_rd) begin
            count_reg <= count_reg + (AW+1)'(1);
         end else if (do_rd && !do_wr) begin
            count_reg <= count_reg - (AW+1)'(1);
         end
      end
   end
endmodule : upfh_fifo

// ### rtl/upfh_sync.sv
// upfh_sync: two flip-flop synchroniser for a vector of pins
// assumes reset value is given per instance
module upfh_sync
   import upfh_pkg::*;
#(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // pins in, synchronised out
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         meta_reg <= RST_VAL;
         sync_reg <= RST_VAL;
      end else begin
         meta_reg <= i_async;
         sync_reg <= meta_reg;
      end
   end

   assign o_sync = sync_reg;
endmodule : upfh_sync

// ### testbench/upfh_port_chk.sv
// upfh_port_chk: pin-level assertions for the parallel fifo port
// assumes one clock domain and the bind at the foot of this file
module upfh_port_chk
   import upfh_pkg::*;
#(
   parameter int RESUME_CYC = UPFH_RESUME_CYC
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // watched pins
   input wire logic i_rd_strobe_n,
   input wire logic i_wr_strobe,
   input wire logic o_fifo_data_oe,
   input wire logic o_tx_space_flag_n,
   input wire logic o_tx_space_flag_n_oe,
   input wire logic o_rx_data_flag_n,
   input wire logic o_rx_data_flag_n_oe,
   input wire logic o_power_enable_n,
   input wire logic o_pull_down_en,
   input wire logic i_remote_wake_en,
   input wire logic i_suspend_pull_en,
   input wire logic i_usb_configured,
   input wire logic i_usb_suspended,
   input wire logic o_resume_req,
   input wire logic o_rx_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   int run_reg;
   always_ff @(posedge i_clk_sys) begin
      if (i_rst || !o_resume_req) run_reg <= 0;
      else run_reg <= run_reg + 1;
   end
   flag_oe_rst_a: assert property ($fell(i_rst) |->
      (!o_tx_space_flag_n_oe && !o_rx_data_flag_n_oe) ##1
      (!o_tx_space_flag_n_oe && !o_rx_data_flag_n_oe) ##1 o_tx_space_flag_n_oe)
      else $error("flag driven or late around reset release");
   bus_release_a: assert property (i_rd_strobe_n[*5] |-> !o_fifo_data_oe)
      else $error("bus driven with read strobe high");
   bus_drive_a: assert property ((!i_rd_strobe_n && !o_power_enable_n)[*5]
      |-> o_fifo_data_oe) else $error("bus not driven during read");
   tx_hold_a: assert property (i_wr_strobe[*5] |-> o_tx_space_flag_n)
      else $error("tx flag low while write strobe high");
   rx_full_a: assert property ((!o_rx_ready && !o_power_enable_n && i_rd_strobe_n)[*5]
      |-> !o_rx_data_flag_n) else $error("rx flag high with full fifo");
   pwr_on_a: assert property ((i_usb_configured && !i_usb_suspended)[*3]
      |-> !o_power_enable_n) else $error("power enable not low when configured");
   pwr_susp_a: assert property (i_usb_suspended[*3] |-> o_power_enable_n)
      else $error("power enable low in suspend");
   wake_in_a: assert property ((i_usb_suspended && i_remote_wake_en)[*5]
      |-> !o_rx_data_flag_n_oe) else $error("rx flag pin still driven in wake mode");
   pull_dn_a: assert property ((i_usb_suspended && i_suspend_pull_en)[*5]
      |-> o_pull_down_en) else $error("suspend pull-down not enabled");
   resume_len_a: assert property ($fell(o_resume_req) |-> run_reg == RESUME_CYC)
      else $error("resume request length wrong");
endmodule : upfh_port_chk

bind upfh_port upfh_port_chk #(.RESUME_CYC(RESUME_CYC)) u_chk (.i_clk_sys(i_clk_sys),
   .i_rst(i_rst), .i_rd_strobe_n(i_rd_strobe_n), .i_wr_strobe(i_wr_strobe),
   .o_fifo_data_oe(o_fifo_data_oe), .o_tx_space_flag_n(o_tx_space_flag_n),
   .o_tx_space_flag_n_oe(o_tx_space_flag_n_oe), .o_rx_data_flag_n(o_rx_data_flag_n),
   .o_rx_data_flag_n_oe(o_rx_data_flag_n_oe), .o_power_enable_n(o_power_enable_n),
   .o_pull_down_en(o_pull_down_en), .i_remote_wake_en(i_remote_wake_en),
   .i_suspend_pull_en(i_suspend_pull_en), .i_usb_configured(i_usb_configured),
   .i_usb_suspended(i_usb_suspended), .o_resume_req(o_resume_req), .o_rx_ready(o_rx_ready));

// ### testbench/upfh_host_model.sv
// upfh_host_model: external controller on the byte bus and strobes
// assumes the bench calls its tasks; resolves shared pins with pulls
module upfh_host_model
   import upfh_pkg::*;
(
   // clock
   input wire logic i_clk_sys,
   // device pins
   input wire logic [7:0] i_dev_data,
   input wire logic i_dev_data_oe,
   input wire logic i_tx_space_flag_n,
   input wire logic i_rx_data_flag_n,
   input wire logic i_rx_flag_oe,
   input wire logic i_pull_down_en,
   // resolved pins
   output logic [7:0] o_bus,
   output logic o_rd_strobe_n,
   output logic o_wr_strobe,
   output logic o_rx_flag_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   logic drv = 1'b0;
   logic wake_low = 1'b0;
   logic [7:0] dat = 8'h00;
   initial begin
      o_rd_strobe_n = 1'b1;
      o_wr_strobe = 1'b0;
   end
   // released lines fall to their weak pull
   always_comb begin
      if (drv) o_bus = dat;
      else if (i_dev_data_oe) o_bus = i_dev_data;
      else o_bus = i_pull_down_en ? 8'h00 : 8'hFF;
      o_rx_flag_pin = wake_low ? 1'b0 : (i_rx_flag_oe ? i_rx_data_flag_n : 1'b1);
   end
   task automatic read_byte(output logic [7:0] b);
      int n;
      n = 0;
      while (i_rx_data_flag_n !== 1'b0 && n < 200) begin
         @(negedge i_clk_sys);
         n++;
      end
      @(negedge i_clk_sys);
      o_rd_strobe_n = 1'b0;
      repeat (5) @(negedge i_clk_sys);
      b = o_bus;
      o_rd_strobe_n = 1'b1;
      repeat (4) @(negedge i_clk_sys);
   endtask : read_byte
   task automatic write_byte(input logic [7:0] b);
      int n;
      n = 0;
      while (i_tx_space_flag_n !== 1'b0 && n < 200) begin
         @(negedge i_clk_sys);
         n++;
      end
      @(negedge i_clk_sys);
      drv = 1'b1;
      dat = b;
      o_wr_strobe = 1'b1;
      repeat (5) @(negedge i_clk_sys);
      o_wr_strobe = 1'b0;
      repeat (4) @(negedge i_clk_sys);
      drv = 1'b0;
      dat = ~b;
      repeat (2) @(negedge i_clk_sys);
   endtask : write_byte
   task automatic wake_pulse();
      @(negedge i_clk_sys);
      wake_low = 1'b1;
      repeat (6) @(negedge i_clk_sys);
      wake_low = 1'b0;
   endtask : wake_pulse
endmodule : upfh_host_model

// ### testbench/tb_top.sv
// tb_top: self-checking bench for the parallel fifo port
// assumes host model on the pins, bench plays the usb engine
module tb_top
   import upfh_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int RES_CYC = 4;
   logic clk = 1'b0, rst = 1'b1, osc = 1'b0, wake_en = 1'b0, pull_en = 1'b0;
   logic cfg = 1'b0, susp = 1'b0, rxv = 1'b0, txr = 1'b0;
   logic [7:0] rxd = 8'h00;
   logic osc_out;
   logic [7:0] bus, dq, txd;
   logic doe, rdn, wr, txf, txf_oe, rxf_pin, rxf, rxf_oe, pwrn, pden, resume, rxr, txv;
   int err_count = 0, checks = 0;
   initial forever #20 clk = ~clk;
   upfh_port #(.RESUME_CYC(RES_CYC)) u_dut (.i_clk_sys(clk), .i_rst(rst), .i_fifo_data(bus),
      .o_fifo_data(dq), .o_fifo_data_oe(doe), .i_rd_strobe_n(rdn), .i_wr_strobe(wr),
      .o_tx_space_flag_n(txf), .o_tx_space_flag_n_oe(txf_oe), .i_rx_data_flag_n(rxf_pin),
      .o_rx_data_flag_n(rxf), .o_rx_data_flag_n_oe(rxf_oe), .o_power_enable_n(pwrn),
      .o_pull_down_en(pden), .i_osc_in(osc), .o_osc_out(osc_out), .i_remote_wake_en(wake_en),
      .i_suspend_pull_en(pull_en), .i_usb_configured(cfg), .i_usb_suspended(susp),
      .o_resume_req(resume), .i_rx_valid(rxv), .i_rx_data(rxd), .o_rx_ready(rxr),
      .o_tx_valid(txv), .o_tx_data(txd), .i_tx_ready(txr));
   upfh_host_model u_host (.i_clk_sys(clk), .i_dev_data(dq), .i_dev_data_oe(doe),
      .i_tx_space_flag_n(txf), .i_rx_data_flag_n(rxf), .i_rx_flag_oe(rxf_oe),
      .i_pull_down_en(pden), .o_bus(bus), .o_rd_strobe_n(rdn), .o_wr_strobe(wr),
      .o_rx_flag_pin(rxf_pin));
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic close_out();
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : close_out
   task automatic push_rx(input logic [7:0] b);
      int n;
      n = 0;
      @(negedge clk);
      rxv = 1'b1;
      rxd = b;
      while (rxr !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      rxv = 1'b0;
   endtask : push_rx
   task automatic t_reset();
      repeat (8) @(negedge clk);
      check({4'h0, txf_oe, rxf_oe, doe, pwrn}, 8'h01);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      check({6'h00, txf_oe, rxf_oe}, 8'h03);
      cfg = 1'b1;
      repeat (4) @(negedge clk);
      check(8'(pwrn), 8'h00);
   endtask : t_reset
   task automatic t_osc();
      osc = 1'b1;
      repeat (5) @(negedge clk);
      check(8'(osc_out), 8'h00);
      osc = 1'b0;
      repeat (5) @(negedge clk);
      check(8'(osc_out), 8'h01);
   endtask : t_osc
   task automatic t_rx();
      logic [7:0] b;
      logic [7:0] exp [8] = '{8'hA5, 8'h3C, 8'h81, 8'h5A, 8'hC3, 8'h18, 8'hE7, 8'h66};
      foreach (exp[i]) push_rx(exp[i]);
      repeat (6) @(negedge clk);
      check(8'(rxf), 8'h00);
      foreach (exp[i]) begin
         u_host.read_byte(b);
         check(b, exp[i]);
      end
      check(8'(rxf), 8'h01);
   endtask : t_rx
   task automatic t_tx();
      int n;
      for (int i = 0; i < 8; i++) u_host.write_byte(8'h10 + 8'(i));
      check(8'(txf), 8'h01);
      for (int i = 0; i < 8; i++) begin
         n = 0;
         while (txv !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
         end
         check(txd, 8'h10 + 8'(i));
         txr = 1'b1;
         @(negedge clk);
         txr = 1'b0;
      end
      repeat (6) @(negedge clk);
      check(8'(txf), 8'h00);
   endtask : t_tx
   task automatic t_wake();
      int n;
      wake_en = 1'b1;
      pull_en = 1'b1;
      susp = 1'b1;
      repeat (6) @(negedge clk);
      check({5'h00, pwrn, rxf_oe, pden}, 8'h05);
      fork
         u_host.wake_pulse();
      join_none
      n = 0;
      while (resume !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      n = 0;
      while (resume === 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      check(8'(n), 8'(RES_CYC));
      susp = 1'b0;
      repeat (4) @(negedge clk);
      check(8'(pwrn), 8'h00);
   endtask : t_wake
   initial begin
      #(40 * 20000);
      err_count++;
      close_out();
   end
   initial begin
      t_reset();
      t_osc();
      t_rx();
      t_tx();
      t_wake();
      close_out();
   end
endmodule : tb_top
